// file: hdl/gros_pkg.sv
// constants shared by supervisor and host
package gros_pkg;
  // clock and timing
  localparam int SYS_CLK_HZ = 50_000_000;
  localparam int WARM_SECS_DEF = 45;
  localparam int TIE_MS = 50;
  localparam int TIE_CYC = SYS_CLK_HZ / 1000 * TIE_MS;
  // bit periods for the four link rates
  localparam int BAUD_0 = 38400;
  localparam int BAUD_1 = 19200;
  localparam int BAUD_2 = 9600;
  localparam int BAUD_3 = 4800;
  localparam logic [15:0] DIV_0 = 16'(SYS_CLK_HZ / BAUD_0);
  localparam logic [15:0] DIV_1 = 16'(SYS_CLK_HZ / BAUD_1);
  localparam logic [15:0] DIV_2 = 16'(SYS_CLK_HZ / BAUD_2);
  localparam logic [15:0] DIV_3 = 16'(SYS_CLK_HZ / BAUD_3);
  // readings in percent of full scale, signed
  localparam logic signed [15:0] RD_HOLD = -16'sd250;
  localparam logic signed [15:0] RD_MIN = -16'sd100;
  localparam logic signed [15:0] RD_MAX = 16'sd200;
  localparam logic signed [15:0] OVR_0 = 16'sd100;
  localparam logic signed [15:0] OVR_1 = 16'sd125;
  localparam logic signed [15:0] OVR_2 = 16'sd150;
  localparam logic signed [15:0] OVR_3 = 16'sd200;
  localparam logic signed [15:0] FS_PCT = 16'sd100;
  // analogue output code
  localparam int DAC_W = 12;
  localparam logic [DAC_W-1:0] DAC_FAULT = 12'h000;
  // link command and answer bytes
  localparam logic [7:0] CMD_READ = 8'h01;
  localparam logic [7:0] CMD_ZERO = 8'h02;
  localparam logic [7:0] CMD_SPAN = 8'h03;
  localparam logic [7:0] ANS_ACK = 8'h06;
  localparam logic [7:0] ANS_NAK = 8'h15;
  // host register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_READ = 8'h0c;
  // host control bits
  localparam int CTRL_READ = 0;
  localparam int CTRL_ZERO = 1;
  localparam int CTRL_SPAN = 2;
  localparam int CTRL_TIE = 3;
  localparam logic [1:0] CFG_RST = 2'h0;
endpackage : gros_pkg

// file: hdl/gros_link_if.sv
// serial link between sensor supervisor and host, with pin tie
`timescale 1ns/1ps
interface gros_link_if;
  logic dev_txd;
  logic host_txd;
  logic host_tie;
  logic dev_rx_line;
  logic host_rx_line;
  // tying both link pins to the negative supply pulls both wires low
  assign dev_rx_line = host_txd & ~host_tie;
  assign host_rx_line = dev_txd & ~host_tie;
  modport dev (output dev_txd, input dev_rx_line);
  modport host (output host_txd, output host_tie, input host_rx_line);
endinterface : gros_link_if

// file: hdl/gros_uart.sv
// 8 data bits, 1 stop bit, no parity transmitter and receiver
`timescale 1ns/1ps
module gros_uart (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // rate select
  input wire logic [1:0] baud_sel,
  // transmit side
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic txd,
  // receive side
  input wire logic rxd,
  output logic [7:0] rx_data,
  output logic rx_valid
);
  logic [15:0] div;
  logic [15:0] tx_cnt_reg;
  logic [3:0] tx_bit_reg;
  logic [9:0] tx_sh_reg;
  logic [15:0] rx_cnt_reg;
  logic [3:0] rx_bit_reg;
  logic [7:0] rx_sh_reg;
  logic rx_busy_reg;

  // bit period from the selected rate
  always_comb begin
    case (baud_sel)
      2'h0: div = gros_pkg::DIV_0;
      2'h1: div = gros_pkg::DIV_1;
      2'h2: div = gros_pkg::DIV_2;
      default: div = gros_pkg::DIV_3;
    endcase
  end

  assign tx_ready = (tx_bit_reg == 4'h0);

  // transmitter: start, eight data lsb first, one stop, no parity
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_bit_reg <= 4'h0;
      tx_cnt_reg <= 16'h0000;
      tx_sh_reg <= 10'h3ff;
      txd <= 1'b1;
    end else if (tx_bit_reg == 4'h0) begin
      if (tx_valid) begin
        tx_sh_reg <= {1'b1, tx_data, 1'b0}; // [R16]
        tx_bit_reg <= 4'ha;
        tx_cnt_reg <= 16'h0000;
      end
    end else if (tx_cnt_reg == 16'h0000) begin
      txd <= tx_sh_reg[0];
      tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
      tx_cnt_reg <= div - 16'h0001;
    end else if (tx_cnt_reg == 16'h0001) begin
      tx_cnt_reg <= 16'h0000;
      tx_bit_reg <= tx_bit_reg - 4'h1;
    end else begin
      tx_cnt_reg <= tx_cnt_reg - 16'h0001;
    end
  end

  // receiver: sample mid-bit, drop frames with a low stop bit
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx_busy_reg <= 1'b0;
      rx_cnt_reg <= 16'h0000;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_busy_reg) begin
        if (!rxd) begin
          rx_busy_reg <= 1'b1;
          rx_cnt_reg <= {1'b0, div[15:1]};
          rx_bit_reg <= 4'h0;
        end
      end else if (rx_cnt_reg != 16'h0000) begin
        rx_cnt_reg <= rx_cnt_reg - 16'h0001;
      end else begin
        rx_cnt_reg <= div - 16'h0001;
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0 && rxd) begin
          rx_busy_reg <= 1'b0; // glitch, not a start bit
        end else if (rx_bit_reg == 4'h9) begin
          rx_busy_reg <= 1'b0;
          rx_data <= rx_sh_reg;
          rx_valid <= rxd; // [R16]
        end else if (rx_bit_reg != 4'h0) begin
          rx_sh_reg <= {rxd, rx_sh_reg[7:1]};
        end
      end
    end
  end
endmodule : gros_uart

// file: hdl/gros_device.sv
// sensor end: reading supervisor, analogue code and link responder
// Operation
// [R1] hold start level for warm-up, default 45s
// [R2] default warm-up level is zero-gas output
// [R3] serial reading -250% FSD during warm-up
// [R4] warm-up level and duration from configuration
// [R5] calculated reading spans -100% to +200%
// [R6] clamp reading at configured over-range limit
// [R7] over-range limit 100, 125, 150, 200%
// [R8] memory, supply, signal checks raise fault
// [R9] fault drives analogue output to 0V
// [R10] fault reports -250% FSD on link
// [R11] host zeroes before any span calibration
// [R12] tied link pins trigger manual calibration
// [R13] ranges 0-1000ppm or 0-1% volume
// [R14] transient freezes output at last value
// [R15] host spans preferably at half range
// [R16] link characters 8 data, 1 stop, no parity
// [R17] resolution 0.01% vol or 20ppm
// [R18] configurable rising or falling analogue output
// [R19] link rates 38400, 19200, 9600, 4800
// [R20] fault outranks warm-up, clamp and freeze
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module gros_device #(
  parameter int CLK_HZ = gros_pkg::SYS_CLK_HZ,
  parameter int TIE_CYCLES = gros_pkg::TIE_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // link
  gros_link_if.dev link,
  // stored configuration
  input wire logic [7:0] cfg_warm_secs,
  input wire logic cfg_warm_custom,
  input wire logic [gros_pkg::DAC_W-1:0] cfg_warm_code,
  input wire logic [gros_pkg::DAC_W-1:0] cfg_zero_code,
  input wire logic [gros_pkg::DAC_W-1:0] cfg_fs_code,
  input wire logic [1:0] cfg_over_sel,
  input wire logic cfg_range_ppm,
  input wire logic cfg_falling,
  input wire logic cfg_manual_cal,
  input wire logic [1:0] cfg_baud_sel,
  // measurement core
  input wire logic signed [15:0] calc_pct,
  input wire logic mem_bad,
  input wire logic supply_bad,
  input wire logic signal_bad,
  input wire logic transient,
  // results
  output logic [gros_pkg::DAC_W-1:0] aout_code,
  output logic signed [15:0] link_reading,
  output logic fault,
  output logic warming,
  output logic cal_zero_pulse,
  output logic cal_span_pulse
);
  initial begin
    if (CLK_HZ < 1 || TIE_CYCLES < 2) $error("bad timing");
  end

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ANS = 4'b0010,
    ST_LO = 4'b0100,
    ST_HI = 4'b1000
  } gros_rsp_type;

  gros_rsp_type rsp_reg;
  logic [31:0] sec_cnt_reg;
  logic [7:0] warm_cnt_reg;
  logic [31:0] tie_cnt_reg;
  logic zero_done_reg;
  logic [7:0] ans_reg;
  logic signed [15:0] held_reg;
  logic signed [15:0] lim;
  logic signed [15:0] clamped;
  logic signed [15:0] quant;
  logic signed [31:0] delta;
  logic signed [31:0] aval;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] rx_data;
  logic rx_valid;
  logic fault_now;

  gros_uart u_uart (
    .sys_clk(sys_clk),
    .srst(srst),
    .baud_sel(cfg_baud_sel), // [R19]
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready),
    .txd(link.dev_txd),
    .rxd(link.dev_rx_line),
    .rx_data(rx_data),
    .rx_valid(rx_valid)
  );

  assign fault_now = mem_bad | supply_bad | signal_bad; // [R8]

  // warm-up timer: one-second enable, configured seconds
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sec_cnt_reg <= 32'h0;
      warm_cnt_reg <= 8'h00;
      warming <= 1'b1;
    end else if (warming) begin
      if (sec_cnt_reg == 32'(CLK_HZ - 1)) begin
        sec_cnt_reg <= 32'h0;
        warm_cnt_reg <= warm_cnt_reg + 8'h01;
      end else begin
        sec_cnt_reg <= sec_cnt_reg + 32'h1;
      end
      if (warm_cnt_reg >= cfg_warm_secs) begin
        warming <= 1'b0; // [R1] [R4]
      end
    end
  end

  // over-range limit, only four choices exist
  always_comb begin
    case (cfg_over_sel)
      2'h0: lim = gros_pkg::OVR_0; // [R7]
      2'h1: lim = gros_pkg::OVR_1;
      2'h2: lim = gros_pkg::OVR_2;
      default: lim = gros_pkg::OVR_3;
    endcase
  end

  // calculation span, then clamp; the ppm range steps in 2% of full scale
  always_comb begin
    clamped = calc_pct;
    if (clamped < gros_pkg::RD_MIN) begin
      clamped = gros_pkg::RD_MIN; // [R5]
    end
    if (clamped > gros_pkg::RD_MAX) begin
      clamped = gros_pkg::RD_MAX;
    end
    if (clamped > lim) begin
      clamped = lim; // [R6]
    end
    quant = clamped;
    if (cfg_range_ppm) begin
      quant = {clamped[15:1], 1'b0}; // [R13] [R17]
    end
  end

  // transient freeze keeps the last good reading
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      held_reg <= 16'sh0000;
    end else if (!transient) begin
      held_reg <= quant; // [R14]
    end
  end

  // analogue scale between zero and full-scale codes
  always_comb begin
    delta = (32'($signed({1'b0, cfg_fs_code})) - 32'($signed({1'b0, cfg_zero_code}))) * 32'(held_reg)
      / 32'(gros_pkg::FS_PCT);
    if (cfg_falling) begin
      aval = 32'($signed({1'b0, cfg_fs_code})) - delta; // [R18]
    end else begin
      aval = 32'($signed({1'b0, cfg_zero_code})) + delta;
    end
    if (aval < 0) begin
      aval = 0;
    end
    if (aval > 32'((1 << gros_pkg::DAC_W) - 1)) begin
      aval = 32'((1 << gros_pkg::DAC_W) - 1);
    end
  end

  // output choice: fault first, then warm-up, then live value
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      aout_code <= gros_pkg::DAC_FAULT;
      link_reading <= gros_pkg::RD_HOLD;
      fault <= 1'b0;
    end else begin
      fault <= fault_now;
      if (fault_now) begin
        aout_code <= gros_pkg::DAC_FAULT; // [R9] [R20]
        link_reading <= gros_pkg::RD_HOLD; // [R10]
      end else if (warming) begin
        aout_code <= cfg_warm_custom ? cfg_warm_code : cfg_zero_code; // [R2] [R4]
        link_reading <= gros_pkg::RD_HOLD; // [R3]
      end else begin
        aout_code <= aval[gros_pkg::DAC_W-1:0];
        link_reading <= held_reg;
      end
    end
  end

  // manual calibration: a long low on the receive pin; first zero, then span
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tie_cnt_reg <= 32'h0;
      zero_done_reg <= 1'b0;
      cal_zero_pulse <= 1'b0;
      cal_span_pulse <= 1'b0;
    end else begin
      cal_zero_pulse <= 1'b0;
      cal_span_pulse <= 1'b0;
      if (link.dev_rx_line || !cfg_manual_cal) begin
        tie_cnt_reg <= 32'h0;
      end else if (tie_cnt_reg != 32'(TIE_CYCLES)) begin
        tie_cnt_reg <= tie_cnt_reg + 32'h1;
        if (tie_cnt_reg == 32'(TIE_CYCLES - 1)) begin
          cal_zero_pulse <= !zero_done_reg; // [R12]
          cal_span_pulse <= zero_done_reg; // [R11]
          zero_done_reg <= !zero_done_reg;
        end
      end
      if (rsp_reg == ST_IDLE && rx_valid && rx_data == gros_pkg::CMD_ZERO) begin
        cal_zero_pulse <= 1'b1;
        zero_done_reg <= 1'b1;
      end else if (rsp_reg == ST_IDLE && rx_valid && rx_data == gros_pkg::CMD_SPAN && zero_done_reg) begin
        cal_span_pulse <= 1'b1; // [R11]
        zero_done_reg <= 1'b0;
      end
    end
  end

  // command responder: ack/nak, or reading low then high
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rsp_reg <= ST_IDLE;
      ans_reg <= 8'h00;
    end else begin
      case (rsp_reg)
        ST_IDLE: begin
          if (rx_valid) begin
            if (rx_data == gros_pkg::CMD_READ) begin
              rsp_reg <= ST_LO;
            end else if (rx_data == gros_pkg::CMD_ZERO) begin
              ans_reg <= gros_pkg::ANS_ACK;
              rsp_reg <= ST_ANS;
            end else if (rx_data == gros_pkg::CMD_SPAN) begin
              ans_reg <= zero_done_reg ? gros_pkg::ANS_ACK : gros_pkg::ANS_NAK;
              rsp_reg <= ST_ANS;
            end
          end
        end
        ST_ANS: if (tx_ready) rsp_reg <= ST_IDLE;
        ST_LO: if (tx_ready) rsp_reg <= ST_HI;
        ST_HI: if (tx_ready) rsp_reg <= ST_IDLE;
        default: rsp_reg <= ST_IDLE;
      endcase
    end
  end

  // transmit feed from the responder state
  always_comb begin
    tx_valid = (rsp_reg != ST_IDLE);
    case (rsp_reg)
      ST_LO: tx_data = link_reading[7:0];
      ST_HI: tx_data = link_reading[15:8];
      default: tx_data = ans_reg;
    endcase
  end
endmodule : gros_device

// file: hdl/gros_host.sv
// host end: apb registers drive link commands and pin-tie calibration
`timescale 1ns/1ps
module gros_host #(
  parameter int TIE_CYCLES = gros_pkg::TIE_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link
  gros_link_if.host link
);
  initial begin
    if (TIE_CYCLES < 1) $error("bad tie length");
  end

  typedef enum logic [4:0] {
    HS_IDLE = 5'b00001,
    HS_SEND = 5'b00010,
    HS_ANS = 5'b00100,
    HS_HI = 5'b01000,
    HS_TIE = 5'b10000
  } gros_hst_type;

  gros_hst_type st_reg;
  logic [1:0] baud_reg;
  logic [7:0] cmd_reg;
  logic [15:0] read_reg;
  logic [31:0] tie_cnt_reg;
  logic zero_ok_reg;
  logic nak_reg;
  logic done_reg;
  logic [7:0] rx_data;
  logic rx_valid;
  logic tx_ready;
  logic acc;
  logic wr_ctrl;

  gros_uart u_uart (
    .sys_clk(sys_clk),
    .srst(srst),
    .baud_sel(baud_reg),
    .tx_data(cmd_reg),
    .tx_valid(st_reg == HS_SEND),
    .tx_ready(tx_ready),
    .txd(link.host_txd),
    .rxd(link.host_rx_line),
    .rx_data(rx_data),
    .rx_valid(rx_valid)
  );

  // access completes one cycle into the access phase
  assign acc = psel & penable & ~pready;
  assign wr_ctrl = acc & pwrite & (paddr == gros_pkg::OFS_CTRL) & (st_reg == HS_IDLE);

  // apb answer and readback
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      baud_reg <= gros_pkg::CFG_RST;
    end else begin
      pready <= acc;
      pslverr <= 1'b0;
      if (acc) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          gros_pkg::OFS_CTRL: ;
          gros_pkg::OFS_CFG: begin
            prdata <= {30'h0, baud_reg};
            if (pwrite) baud_reg <= pwdata[1:0];
          end
          gros_pkg::OFS_STAT: prdata <= {28'h0, zero_ok_reg, nak_reg, done_reg, st_reg != HS_IDLE};
          gros_pkg::OFS_READ: prdata <= {{16{read_reg[15]}}, read_reg};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // command sequencer; span without a prior zero is refused with nak
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_reg <= HS_IDLE;
      cmd_reg <= 8'h00;
      read_reg <= 16'h0000;
      tie_cnt_reg <= 32'h0;
      zero_ok_reg <= 1'b0;
      nak_reg <= 1'b0;
      done_reg <= 1'b0;
      link.host_tie <= 1'b0;
    end else begin
      case (st_reg)
        HS_IDLE: begin
          if (wr_ctrl) begin
            done_reg <= 1'b0;
            nak_reg <= 1'b0;
            if (pwdata[gros_pkg::CTRL_TIE]) begin
              link.host_tie <= 1'b1; // [R12]
              tie_cnt_reg <= 32'h0;
              st_reg <= HS_TIE;
            end else if (pwdata[gros_pkg::CTRL_READ]) begin
              cmd_reg <= gros_pkg::CMD_READ;
              st_reg <= HS_SEND;
            end else if (pwdata[gros_pkg::CTRL_ZERO]) begin
              cmd_reg <= gros_pkg::CMD_ZERO;
              st_reg <= HS_SEND;
            end else if (pwdata[gros_pkg::CTRL_SPAN] && zero_ok_reg) begin
              cmd_reg <= gros_pkg::CMD_SPAN; // [R11]
              st_reg <= HS_SEND;
            end else if (pwdata[gros_pkg::CTRL_SPAN]) begin
              nak_reg <= 1'b1;
              done_reg <= 1'b1;
            end
          end
        end
        HS_SEND: if (tx_ready) st_reg <= HS_ANS;
        HS_ANS: begin
          if (rx_valid) begin
            if (cmd_reg == gros_pkg::CMD_READ) begin
              read_reg[7:0] <= rx_data;
              st_reg <= HS_HI;
            end else begin
              nak_reg <= (rx_data != gros_pkg::ANS_ACK);
              zero_ok_reg <= (cmd_reg == gros_pkg::CMD_ZERO) && (rx_data == gros_pkg::ANS_ACK);
              done_reg <= 1'b1;
              st_reg <= HS_IDLE;
            end
          end
        end
        HS_HI: begin
          if (rx_valid) begin
            read_reg[15:8] <= rx_data;
            done_reg <= 1'b1;
            st_reg <= HS_IDLE;
          end
        end
        HS_TIE: begin
          tie_cnt_reg <= tie_cnt_reg + 32'h1;
          if (tie_cnt_reg == 32'(TIE_CYCLES - 1)) begin
            link.host_tie <= 1'b0;
            zero_ok_reg <= !zero_ok_reg; // device alternates zero then span
            done_reg <= 1'b1;
            st_reg <= HS_IDLE;
          end
        end
        default: st_reg <= HS_IDLE;
      endcase
    end
  end

endmodule : gros_host

// file: dv/gros_link_monitor.sv
// concurrent checks on the link wires and the supervisor outputs
`timescale 1ns/1ps
module gros_link_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // link wires
  input wire logic dev_txd,
  input wire logic host_txd,
  input wire logic host_tie,
  input wire logic dev_rx_line,
  input wire logic host_rx_line,
  // supervisor inputs
  input wire logic [1:0] cfg_baud_sel,
  input wire logic [1:0] cfg_over_sel,
  input wire logic cfg_warm_custom,
  input wire logic [gros_pkg::DAC_W-1:0] cfg_warm_code,
  input wire logic [gros_pkg::DAC_W-1:0] cfg_zero_code,
  input wire logic mem_bad,
  input wire logic supply_bad,
  input wire logic signal_bad,
  input wire logic transient,
  // supervisor outputs
  input wire logic [gros_pkg::DAC_W-1:0] aout_code,
  input wire logic signed [15:0] link_reading,
  input wire logic fault,
  input wire logic warming
);
  localparam logic signed [15:0] LIM_T [4] = '{gros_pkg::OVR_0, gros_pkg::OVR_1, gros_pkg::OVR_2, gros_pkg::OVR_3};
  localparam int DIV_T [4] = '{gros_pkg::DIV_0, gros_pkg::DIV_1, gros_pkg::DIV_2, gros_pkg::DIV_3};
  logic bad_any;
  logic [16:0] low_cnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // any failed self-check
  assign bad_any = mem_bad | supply_bad | signal_bad;
  // low run on device out
  always_ff @(posedge sys_clk) begin
    if (srst || dev_txd) begin
      low_cnt <= 17'h00000;
    end else begin
      low_cnt <= low_cnt + 17'h00001;
    end
  end
  property p_warm_read;
    warming |-> link_reading == gros_pkg::RD_HOLD;
  endproperty
  a_warm_read: assert property (p_warm_read) else $error("warm read");
  property p_warm_aout;
    warming && !fault && !$past(srst) |->
      aout_code == $past(cfg_warm_custom ? cfg_warm_code : cfg_zero_code);
  endproperty
  a_warm_aout: assert property (p_warm_aout) else $error("warm level");
  property p_fault_src;
    !$past(srst) |-> fault == $past(bad_any);
  endproperty
  a_fault_src: assert property (p_fault_src) else $error("fault source");
  property p_fault_aout;
    fault |-> aout_code == gros_pkg::DAC_FAULT;
  endproperty
  a_fault_aout: assert property (p_fault_aout) else $error("fault output");
  property p_fault_read;
    fault |-> link_reading == gros_pkg::RD_HOLD;
  endproperty
  a_fault_read: assert property (p_fault_read) else $error("fault read");
  // the reading lags its inputs by two edges: held value, then output flop
  property p_clamp;
    !fault && !$past(warming) && !$past(transient, 2) && !$past(srst) |->
      link_reading >= gros_pkg::RD_MIN && link_reading <= LIM_T[$past(cfg_over_sel, 2)];
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp");
  property p_freeze;
    !$past(srst) && !$past(srst, 2) && $past(transient, 2) && !fault && !$past(fault) && !$past(warming, 2) |->
      $stable(link_reading);
  endproperty
  a_freeze: assert property (p_freeze) else $error("freeze");
  property p_tie;
    host_tie |-> !dev_rx_line && !host_rx_line;
  endproperty
  a_tie: assert property (p_tie) else $error("tie");
  property p_idle;
    $past(srst) |-> dev_txd && host_txd;
  endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_low_run;
    low_cnt <= 17'(9 * DIV_T[cfg_baud_sel] + 4);
  endproperty
  a_low_run: assert property (p_low_run) else $error("low run");
  // main scenarios
  c_fault: cover property (fault);
  c_warm_done: cover property ($fell(warming));
  c_tie: cover property ($rose(host_tie));
endmodule : gros_link_monitor

// file: dv/tb_top.sv
// bench joining sensor and host ends over the link
`timescale 1ns/1ps
module tb_top;
  // short second and tie
  localparam int WARM_HZ = 100;
  localparam int TIE_N = 13500;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e;
  logic [7:0] cfg_warm_secs = 8'h03;
  logic cfg_warm_custom = 1'b0, cfg_range_ppm = 1'b0, cfg_falling = 1'b0, cfg_manual_cal = 1'b1;
  logic [gros_pkg::DAC_W-1:0] cfg_warm_code = 12'h7a0, cfg_zero_code = 12'h100, cfg_fs_code = 12'h900;
  logic [1:0] cfg_over_sel = 2'h3, cfg_baud_sel = 2'h0;
  logic signed [15:0] calc_pct = 16'sh0000, link_reading;
  logic mem_bad = 1'b0, supply_bad = 1'b0, signal_bad = 1'b0, transient = 1'b0;
  logic [gros_pkg::DAC_W-1:0] aout_code;
  logic fault, warming, cal_zero_pulse, cal_span_pulse;
  int n_mismatch = 0, n_checks = 0, nz = 0, ns = 0, k;
  gros_link_if i_gros_link_if ();
  gros_device #(.CLK_HZ(WARM_HZ), .TIE_CYCLES(TIE_N)) i_gros_device (.sys_clk, .srst,
    .link(i_gros_link_if.dev), .cfg_warm_secs, .cfg_warm_custom, .cfg_warm_code, .cfg_zero_code,
    .cfg_fs_code, .cfg_over_sel, .cfg_range_ppm, .cfg_falling, .cfg_manual_cal, .cfg_baud_sel,
    .calc_pct, .mem_bad, .supply_bad, .signal_bad, .transient, .aout_code, .link_reading, .fault,
    .warming, .cal_zero_pulse, .cal_span_pulse);
  gros_host #(.TIE_CYCLES(TIE_N)) i_gros_host (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .link(i_gros_link_if.host));
  gros_link_monitor i_gros_link_monitor (.sys_clk, .srst, .dev_txd(i_gros_link_if.dev_txd),
    .host_txd(i_gros_link_if.host_txd), .host_tie(i_gros_link_if.host_tie),
    .dev_rx_line(i_gros_link_if.dev_rx_line), .host_rx_line(i_gros_link_if.host_rx_line),
    .cfg_baud_sel, .cfg_over_sel, .cfg_warm_custom, .cfg_warm_code, .cfg_zero_code, .mem_bad,
    .supply_bad, .signal_bad, .transient, .aout_code, .link_reading, .fault, .warming);
  // 50 mhz clock
  always #10 sys_clk = ~sys_clk;
  // count calibration pulses
  always @(posedge sys_clk) begin
    if (cal_zero_pulse === 1'b1) nz++;
    if (cal_span_pulse === 1'b1) ns++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  // sample mid-cycle
  task automatic smp;
    @(negedge sys_clk);
  endtask : smp
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 20) begin
      n_mismatch++;
      end_of_test();
    end
  endtask : apb
  // control write, then poll until done
  task automatic cmd(input int b);
    apb(1'b1, gros_pkg::OFS_CTRL, 32'h1 << b);
    k = 0;
    do begin
      apb(1'b0, gros_pkg::OFS_STAT, 32'h0);
      k++;
    end while ((q[0] !== 1'b0 || q[1] !== 1'b1) && k < 20000);
    if (k >= 20000) begin
      n_mismatch++;
      end_of_test();
    end
  endtask : cmd
  // expected clamped reading
  function automatic logic signed [15:0] exp_rd(input logic signed [15:0] c, input logic [1:0] s);
    logic signed [15:0] l;
    l = (s == 2'h0) ? gros_pkg::OVR_0 : (s == 2'h1) ? gros_pkg::OVR_1 : (s == 2'h2) ? gros_pkg::OVR_2 : gros_pkg::OVR_3;
    if (c < gros_pkg::RD_MIN) c = gros_pkg::RD_MIN;
    if (c > l) c = l;
    return c;
  endfunction : exp_rd
  initial begin
    void'($urandom(50));
    cyc(2);
    srst <= 1'b0;
    calc_pct <= 16'sd80;
    cyc(100);
    smp;
    chk(link_reading, gros_pkg::RD_HOLD, "warm read");
    chk(aout_code, cfg_zero_code, "warm level");
    k = 100;
    while (warming === 1'b1 && k < 400) begin
      smp;
      k++;
    end
    chk(k > 295 && k < 306, 1'b1, "warm length");
    // each limit just above, then random readings
    for (int i = 0; i < 28; i++) begin
      cyc(1);
      cfg_over_sel <= (i < 4) ? 2'(i) : 2'($urandom_range(3));
      calc_pct <= (i < 4) ? exp_rd(16'sd300, 2'(i)) + 16'sd1 : 16'($urandom_range(400)) - 16'sd150;
      cyc(2);
      smp;
      chk(link_reading, exp_rd(calc_pct, cfg_over_sel), "clamp");
    end
    // freeze holds the old value
    cyc(1);
    cfg_over_sel <= 2'h3;
    calc_pct <= 16'sd40;
    cyc(2);
    transient <= 1'b1;
    calc_pct <= 16'sd60;
    cyc(3);
    smp;
    chk(link_reading, 16'sd40, "frozen");
    cyc(1);
    transient <= 1'b0;
    cyc(2);
    smp;
    chk(link_reading, 16'sd60, "thawed");
    // ppm step, rising and falling
    cyc(1);
    calc_pct <= 16'sd25;
    cfg_range_ppm <= 1'b1;
    cyc(2);
    smp;
    chk(link_reading[0], 1'b0, "ppm step");
    cyc(1);
    cfg_range_ppm <= 1'b0;
    cyc(2);
    smp;
    chk(aout_code, cfg_zero_code + (cfg_fs_code - cfg_zero_code) / 4, "rising");
    cyc(1);
    cfg_falling <= 1'b1;
    cyc(2);
    smp;
    chk(aout_code, cfg_fs_code - (cfg_fs_code - cfg_zero_code) / 4, "falling");
    // each check alone, with freeze and over-range
    for (int i = 0; i < 3; i++) begin
      cyc(1);
      {mem_bad, supply_bad, signal_bad} <= 3'h4 >> i;
      transient <= 1'b1;
      calc_pct <= 16'sd300;
      cyc(2);
      smp;
      chk({fault, aout_code}, {1'b1, gros_pkg::DAC_FAULT}, "fault out");
      chk(link_reading, gros_pkg::RD_HOLD, "fault read");
    end
    cyc(1);
    {mem_bad, supply_bad, signal_bad, transient, cfg_falling} <= 5'h00;
    calc_pct <= -16'sd57;
    apb(1'b0, 8'h40, 32'h0);
    chk(e, 1'b1, "unmapped");
    cmd(gros_pkg::CTRL_SPAN);
    chk(q[2], 1'b1, "span first");
    cmd(gros_pkg::CTRL_READ);
    apb(1'b0, gros_pkg::OFS_READ, 32'h0);
    chk(q, 32'hffff_ffc7, "link read");
    cmd(gros_pkg::CTRL_ZERO);
    chk({q[3:0], nz[7:0], ns[7:0]}, 20'ha0100, "link zero");
    // ties now give span, then zero
    calc_pct <= 16'sd50;
    cmd(gros_pkg::CTRL_TIE);
    cyc(30);
    chk({nz[7:0], ns[7:0]}, 16'h0101, "tie span");
    cmd(gros_pkg::CTRL_TIE);
    cyc(30);
    chk({nz[7:0], ns[7:0]}, 16'h0201, "tie zero");
    // custom warm level after a fresh reset
    cyc(1);
    cfg_warm_custom <= 1'b1;
    srst <= 1'b1;
    cyc(2);
    srst <= 1'b0;
    cyc(3);
    smp;
    chk({warming, aout_code}, {1'b1, cfg_warm_code}, "custom warm");
    end_of_test();
  end
endmodule : tb_top
